/* File: dv/host.sv */
// host spi master model: select, serial clock, data lanes
// assumes aclk paces it, four cycles per clock half
`timescale 1ns/1ps
module host (
	// clock
	input wire logic aclk,
	// lanes
	input wire logic [3:0] dq_wire,
	output logic cs_n,
	output logic sclk,
	output logic [3:0] dq_drv,
	output logic [3:0] dq_en
);
	logic cpol = 1'b0;
	logic [1:0] lvl = 2'b11;
	logic q_r = 1'b0;
	logic [3:0] d_r = 4'h0;
	assign dq_drv = q_r ? d_r : {lvl, d_r[1:0]};
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		dq_en = 4'hc;
	end
	task automatic half();
		repeat (4) @(posedge aclk);
	endtask
	task automatic sel(input logic lo);
		@(posedge aclk);
		sclk <= cpol;
		half();
		cs_n <= !lo;
		dq_en <= 4'hc;
		q_r <= 1'b0;
		half();
	endtask
	task automatic xfer(input logic [7:0] b, input int w, input int n, input logic rd,
		output logic [7:0] got);
		got = 8'h00;
		for (int i = 8 - w; i >= 8 - n; i -= w)
		begin
			@(posedge aclk);
			sclk <= 1'b0;
			q_r <= w == 4 && !rd;
			dq_en <= rd ? 4'hc : (w == 1 ? 4'hd : 4'hf);
			d_r <= 4'(b >> i);
			half();
			sclk <= 1'b1;
			half();
			got = {got[6:0], dq_wire[1]};
		end
	endtask
endmodule

/* File: dv/sflash_properties.sv */
// port checker of the front end
// assumes four aclk cycles per serial clock half
`timescale 1ns/1ps
module sflash_properties (
	// clock
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// bus
	input wire sflash_pkg::axi_req_t axi_req,
	input wire sflash_pkg::axi_rsp_t axi_rsp,
	// pins
	input wire sflash_pkg::pin_in_t pins,
	input wire sflash_pkg::pin_out_t pins_out,
	input wire logic active_power
);
	logic [3:0] hi_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !pins.cs_n)
			hi_r <= 4'h0;
		else if (hi_r != 4'hf)
			hi_r <= hi_r + 4'h1;
	end
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	desel_float_a: assert property (hi_r > 4'h6 |-> pins_out.dq_oe == 4'h0)
		else $error("lanes driven deselected");
	sel_active_a: assert property (!pins.cs_n [*8] |-> active_power)
		else $error("selected not active");
	standby_when_a: assert property ($fell(active_power) |-> hi_r > 4'h1)
		else $error("standby while selected");
	ce_freeze_a: assert property (!ce |=> $stable(pins_out) && $stable(axi_rsp))
		else $error("moved without enable");
	b_release_a: assert property (axi_rsp.bvalid && axi_req.bready
		|=> !axi_rsp.bvalid && axi_rsp.awready && axi_rsp.wready)
		else $error("write answer not released");
	r_release_a: assert property (axi_rsp.rvalid && axi_req.rready
		|=> !axi_rsp.rvalid && axi_rsp.arready)
		else $error("read answer not released");
	rd_late_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("read answer late");
	wr_late_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
		&& axi_rsp.wready |-> ##2 axi_rsp.bvalid)
		else $error("write answer late");
	rd_c: cover property (axi_req.arvalid && axi_rsp.arready);
	oe_c: cover property (pins_out.dq_oe[1]);
	stby_c: cover property ($fell(active_power));
endmodule

/* File: dv/tb_top.sv */
// bench top: front end, host model, bus tasks, tests
// assumes the checker bound below
`timescale 1ns/1ps
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic vpp = 1'b0;
	logic tog = 1'b0;
	logic [3:0] strb = 4'hf;
	sflash_pkg::axi_req_t rq = '0;
	sflash_pkg::axi_rsp_t rs;
	sflash_pkg::pin_out_t po;
	logic act;
	logic cs_n;
	logic sclk;
	logic [3:0] drv;
	logic [3:0] en;
	logic [3:0] oe;
	logic [3:0] dqw;
	int failures = 0;
	int tests_run = 0;
	localparam logic [7:0] vt[4] = '{8'hbf, 8'h7f, 8'h3f, 8'hff};
	localparam logic [1:0] pt[4] = '{2'd1, 2'd2, 2'd1, 2'd0};
	localparam int wt[4] = '{2, 4, 2, 1};
	always #12.5 aclk = !aclk;
	always @(posedge aclk) tog <= !tog;
	assign oe = aresetn ? po.dq_oe : 4'h0;
	assign dqw = (oe & po.dq_out) | (~oe & en & drv) | (~oe & ~en & {4{tog}});
	host host_i (.aclk(aclk), .dq_wire(dqw), .cs_n(cs_n), .sclk(sclk), .dq_drv(drv),
		.dq_en(en));
	serial_flash_bus_front_end #(.BOOST_WAIT(200))
		serial_flash_bus_front_end_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.axi_req(rq), .axi_rsp(rs), .pins(sflash_pkg::pin_in_t'({cs_n, sclk, dqw, vpp})),
		.pins_out(po), .active_power(act));
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		logic b;
		@(posedge aclk);
		rq.awvalid <= 1'b1;
		rq.awaddr <= a;
		rq.wvalid <= 1'b1;
		rq.wdata <= d;
		rq.wstrb <= strb;
		rq.bready <= 1'b1;
		b = 1'b0;
		while (!b)
		begin
			@(negedge aclk);
			aw = rq.awvalid && rs.awready;
			w = rq.wvalid && rs.wready;
			b = rs.bvalid;
			r = rs.bresp;
			@(posedge aclk);
			if (aw) rq.awvalid <= 1'b0;
			if (w) rq.wvalid <= 1'b0;
			if (b) rq.bready <= 1'b0;
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar;
		logic v;
		@(posedge aclk);
		rq.arvalid <= 1'b1;
		rq.araddr <= a;
		rq.rready <= 1'b1;
		v = 1'b0;
		while (!v)
		begin
			@(negedge aclk);
			ar = rq.arvalid && rs.arready;
			v = rs.rvalid;
			d = rs.rdata;
			r = rs.rresp;
			@(posedge aclk);
			if (ar) rq.arvalid <= 1'b0;
			if (v) rq.rready <= 1'b0;
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string nm);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(nm, e, d & m);
	endtask
	task automatic frm(input logic [7:0] op, input int ow, input int aw, input int dw,
		input logic [7:0] dat);
		logic [7:0] g;
		host_i.sel(1'b1);
		host_i.xfer(op, ow, 8, 1'b0, g);
		repeat (3) host_i.xfer(8'h00, aw, 8, 1'b0, g);
		host_i.xfer(dat, dw, 8, 1'b0, g);
		host_i.sel(1'b0);
	endtask
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] g;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc(sflash_pkg::REG_NONVOLATILE_CONFIG_REG, 32'hffff, 32'hffff, "nonvolatile_config_reg");
		rc(sflash_pkg::REG_VOLATILE_ENHANCED_CONFIG_REG, 32'hff, 32'hff, "volatile_enhanced_config_reg");
		rc(sflash_pkg::REG_STAT, 32'h3, 32'h0, "proto");
		rd(8'h18, d, r);
		chk("unmapped", {30'h0, sflash_pkg::RESP_SLVERR}, {d[29:0], r});
		strb = 4'h2;
		wr(sflash_pkg::REG_NONVOLATILE_CONFIG_REG, 32'h0, r);
		strb = 4'hf;
		chk("bresp", {30'h0, sflash_pkg::RESP_OKAY}, {30'h0, r});
		rc(sflash_pkg::REG_NONVOLATILE_CONFIG_REG, 32'hffff, 32'h00ff, "strobe");
		ce <= 1'b0;
		repeat (3) @(posedge aclk);
		ce <= 1'b1;
		$display("reset test done");
		frm(sflash_pkg::OP_PROG, 1, 1, 1, 8'h3c);
		rc(sflash_pkg::REG_STAT, 32'h10, 32'h10, "busy");
		@(negedge aclk);
		chk("active", 32'h1, {31'h0, act});
		repeat (80) @(negedge aclk);
		chk("standby", 32'h0, {31'h0, act});
		rc(sflash_pkg::REG_RX, 32'hffff, {16'h0, 8'h3c, sflash_pkg::OP_PROG}, "rx");
		$display("program test done");
		for (int m = 0; m < 2; m++)
		begin
			wr(sflash_pkg::REG_TX, 32'h5a + m, r);
			host_i.cpol = m[0];
			host_i.sel(1'b1);
			host_i.xfer(sflash_pkg::OP_READ, 1, 8, 1'b0, g);
			repeat (3) host_i.xfer(8'h00, 1, 8, 1'b0, g);
			host_i.xfer(8'h00, 1, 8, 1'b1, g);
			chk("read", 32'h5a + m, {24'h0, g});
			host_i.sel(1'b0);
		end
		$display("read test done");
		for (int k = 0; k < 4; k++)
		begin
			wr(sflash_pkg::REG_VOLATILE_ENHANCED_CONFIG_REG, {24'h0, vt[k]}, r);
			rc(sflash_pkg::REG_STAT, 32'h3, {30'h0, pt[k]}, "proto");
			frm(8'h69 + 8'(k), wt[k], wt[k], wt[k], 8'h81 + 8'(k));
			rc(sflash_pkg::REG_RX, 32'hffff, {16'h0, 8'h81 + 8'(k), 8'h69 + 8'(k)}, "rx");
		end
		$display("protocol test done");
		for (int e = 0; e < 2; e++)
		begin
			wr(sflash_pkg::REG_VOLATILE_ENHANCED_CONFIG_REG, e ? 32'hff : 32'hef, r);
			host_i.sel(1'b1);
			host_i.xfer(8'h3c, 1, 4, 1'b0, g);
			host_i.lvl[1] <= 1'b0;
			repeat (2) @(posedge aclk);
			rc(sflash_pkg::REG_STAT, 32'h20, e ? 32'h20 : 32'h0, "paused");
			host_i.xfer(8'hff, 1, 4, 1'b0, g);
			host_i.lvl[1] <= 1'b1;
			host_i.xfer(8'hc0, 1, 4, 1'b0, g);
			host_i.sel(1'b0);
			rc(sflash_pkg::REG_RX, 32'hff, e ? 32'h3c : 32'h3f, "op");
		end
		$display("pause test done");
		for (int k = 0; k < 2; k++)
		begin
			host_i.lvl[0] <= k[0];
			repeat (4) @(posedge aclk);
			wr(sflash_pkg::REG_BP, 32'h5, r);
			rc(sflash_pkg::REG_BP, 32'hf, k ? 32'h5 : 32'h0, "bp");
		end
		$display("protect test done");
		for (int k = 0; k < 2; k++)
		begin
			wr(sflash_pkg::REG_VOLATILE_ENHANCED_CONFIG_REG, k ? 32'hf7 : 32'hff, r);
			frm(sflash_pkg::OP_QIN_PROG, 1, 1, 4, 8'h99);
			vpp <= 1'b1;
			repeat (6) @(posedge aclk);
			rc(sflash_pkg::REG_STAT, 32'h100, k ? 32'h100 : 32'h0, "boost");
			repeat (24) @(posedge aclk);
			rc(sflash_pkg::REG_STAT, 32'h10, k ? 32'h0 : 32'h10, "speed");
			vpp <= 1'b0;
			repeat (80) @(posedge aclk);
		end
		$display("boost test done");
		summarize();
	end
	initial
	begin
		repeat (60000) @(posedge aclk);
		failures++;
		summarize();
	end
endmodule
bind serial_flash_bus_front_end sflash_properties sflash_properties_i (.aclk(aclk),
	.aresetn(aresetn), .ce(ce), .axi_req(axi_req), .axi_rsp(axi_rsp), .pins(pins),
	.pins_out(pins_out), .active_power(active_power));

/* File: hw/lane_shifter.sv */
// shifts 1, 2 or 4 data lines into bytes and bytes out onto lines
// assumes rise and fall are one-cycle serial clock edge strobes
`timescale 1ns/1ps
module lane_shifter (
	// clock
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// control
	input wire logic clear,
	input wire logic rise,
	input wire logic fall,
	input wire logic load,
	input wire logic [2:0] width,
	// data
	input wire logic [3:0] din,
	input wire logic [7:0] tx_byte,
	output logic done,
	output logic [7:0] rx_byte,
	output logic [3:0] dout
);
	typedef struct packed {
		logic [7:0] rx;
		logic [3:0] cnt;
		logic done;
		logic [7:0] tx;
		logic [3:0] tcnt;
		logic [3:0] dout;
	} shift_t;
	shift_t st_r;
	shift_t st_nxt;
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (clear)
		begin
			st_nxt.cnt = 4'h0;
			st_nxt.tcnt = 4'h0;
		end
		else
		begin
			if (rise)
			begin
				case (width)
					3'd4: st_nxt.rx = {st_r.rx[3:0], din};
					3'd2: st_nxt.rx = {st_r.rx[5:0], din[1:0]};
					default: st_nxt.rx = {st_r.rx[6:0], din[0]};
				endcase
				st_nxt.cnt = st_r.cnt + {1'b0, width};
				if (st_nxt.cnt >= 4'h8)
				begin
					st_nxt.cnt = 4'h0;
					st_nxt.done = 1'b1;
				end
			end
			if (load)
			begin
				st_nxt.tx = tx_byte;
				st_nxt.tcnt = 4'h0;
			end
			else if (fall)
			begin
				case (width)
					3'd4: st_nxt.dout = st_r.tx[7:4];
					3'd2: st_nxt.dout = {2'b00, st_r.tx[7:6]};
					default: st_nxt.dout = {2'b00, st_r.tx[7], 1'b0};
				endcase
				st_nxt.tx = st_r.tx << width;
				st_nxt.tcnt = st_r.tcnt + {1'b0, width};
				if (st_nxt.tcnt >= 4'h8)
				begin
					st_nxt.tx = tx_byte;
					st_nxt.tcnt = 4'h0;
				end
			end
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_r <= '0;
		else if (ce)
			st_r <= st_nxt;
	end
	assign done = st_r.done;
	assign rx_byte = st_r.rx;
	assign dout = st_r.dout;
endmodule

/* File: hw/pin_sync.sv */
// two-flop synchroniser for a group of pin levels
// assumes pins are asynchronous to aclk
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;
	sync_t st_r;
	sync_t st_nxt;
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_r <= '{s1: RST, s2: RST};
		else if (ce)
			st_r <= st_nxt;
	end
	assign q = st_r.s2;
endmodule

/* File: hw/serial_flash_bus_front_end.sv */
// serial bus front end of a serial flash: select, pause/reset, protect/boost, protocols
// assumes an axi4-lite master on aclk and serial pins asynchronous to aclk
//
// Notes on behaviour
// R01: select high deselects and floats data_io_1.
// R02: deselected, stay active until the internal cycle ends, then standby.
// R03: select low selects the device and makes it active.
// R04: only a falling select edge after power-up starts an instruction.
// R05: pause freezes shifting and floats outputs; input and clock ignored.
// R06: host starts pause only while select is low.
// R07: reset variant: pin high runs normally, low resets with outputs floated.
// R08: reset during an internal cycle aborts it and marks data lost.
// R09: single-line protocol quad instructions use the pause pin as data_io_3.
// R10: four-line protocol selected uses pin as data_io_3; deselected, reset allowed.
// R11: nonvolatile bit 3 or volatile bit 4 cleared disables pause/reset.
// R12: single/dual instructions: low write-protect freezes block_protect_bits; code freezes them only in the single-line protocol.
// R13: protect pin is data_io_2 in quad reads and four-line protocol.
// R14: boost allowed only when volatile bit 3 is 0; default 1.
// R15: after quad program, wait 200 ms for boost, else standard speed.
// R16: modes 0 and 3: latch on rising clock, drive after falling clock.
// R17: host parks the clock low or high when idle.
// R18: one protocol at a time chosen by configuration bits, never mixed.
// R19: single-line protocol sends opcode on data_io_0, rest per instruction.
// R20: two-line protocol carries every phase on data_io_0 and data_io_1.
// R21: volatile bit 6 cleared selects two-line protocol until power-on.
// R22: power-on protocol: nonvolatile bit 2 low dual, bit 3 low quad; code picks dual when both are low.
// R23: four-line protocol carries every phase on data_io_0 to data_io_3.
// R24: volatile bit 7 cleared selects four-line protocol until power-on; code picks two-line instead when bit 6 is also cleared.
// R25: opcode, address and data are latched on the rising clock edge.
// R26: each select-low period is one frame; early rise discards partial instruction.
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module serial_flash_bus_front_end #(
	parameter bit RESET_VARIANT = 1'b0,
	parameter logic [15:0] NONVOLATILE_CONFIG_REG_INIT = sflash_pkg::NONVOLATILE_CONFIG_REG_RST,
	parameter int BOOST_WAIT = sflash_pkg::BOOST_WAIT_CYC,
	parameter int PROG = sflash_pkg::PROG_CYC,
	parameter int FAST = sflash_pkg::FAST_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// register bus
	input wire sflash_pkg::axi_req_t axi_req,
	output sflash_pkg::axi_rsp_t axi_rsp,
	// serial pins
	input wire sflash_pkg::pin_in_t pins,
	output sflash_pkg::pin_out_t pins_out,
	// power state
	output logic active_power
);
	typedef struct packed {
		sflash_pkg::frame_t fst;
		sflash_pkg::cycle_t cst;
		sflash_pkg::proto_t proto;
		logic cs_prev;
		logic sclk_prev;
		logic [7:0] opcode;
		logic [7:0] data_byte;
		logic [7:0] byte_cnt;
		logic [15:0] nonvolatile_config_reg;
		logic [7:0] volatile_enhanced_config_reg;
		logic [3:0] bp;
		logic [7:0] tx;
		logic [sflash_pkg::CNT_W-1:0] cnt;
		logic boosted;
		logic lost;
		logic drv;
		logic load;
		logic [3:0] oe;
		logic active;
		logic aw_ok;
		logic [7:0] aw_addr;
		logic w_ok;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

	localparam logic [7:0] VOLATILE_ENHANCED_CONFIG_REG_INIT = {NONVOLATILE_CONFIG_REG_INIT[sflash_pkg::NV_QUAD_N],
		NONVOLATILE_CONFIG_REG_INIT[sflash_pkg::NV_DUAL_N], sflash_pkg::VOLATILE_ENHANCED_CONFIG_REG_RST[5:0]};
	localparam int AB = sflash_pkg::ADDR_BYTES;

	function automatic sflash_pkg::proto_t proto_of(input logic [7:0] v);
		if (!v[sflash_pkg::VE_DUAL_N])
			return sflash_pkg::P_DUAL;
		else if (!v[sflash_pkg::VE_QUAD_N])
			return sflash_pkg::P_QUAD;
		return sflash_pkg::P_SINGLE;
	endfunction

	function automatic sflash_pkg::op_info_t decode(input logic [7:0] op,
		input sflash_pkg::proto_t pr);
		sflash_pkg::op_info_t o;
		o = '{is_read: 1'b0, is_prog: 1'b0, quad: 1'b0, addr_w: 3'd1, data_w: 3'd1};
		case (op)
			sflash_pkg::OP_READ: o.is_read = 1'b1;
			sflash_pkg::OP_QOUT_READ: o = '{1'b1, 1'b0, 1'b1, 3'd1, 3'd4};
			sflash_pkg::OP_QIO_READ: o = '{1'b1, 1'b0, 1'b1, 3'd4, 3'd4};
			sflash_pkg::OP_PROG: o.is_prog = 1'b1;
			sflash_pkg::OP_QIN_PROG: o = '{1'b0, 1'b1, 1'b1, 3'd1, 3'd4};
			sflash_pkg::OP_QEXT_PROG: o = '{1'b0, 1'b1, 1'b1, 3'd4, 3'd4};
			default: o.is_prog = 1'b0;
		endcase
		// whole frame on two or four lines [R20] [R23]
		if (pr == sflash_pkg::P_DUAL)
		begin
			o.addr_w = 3'd2;
			o.data_w = 3'd2;
			o.quad = 1'b0;
		end
		else if (pr == sflash_pkg::P_QUAD)
		begin
			o.addr_w = 3'd4;
			o.data_w = 3'd4;
			o.quad = 1'b1;
		end
		return o;
	endfunction

	localparam state_t ST_RST = '{
		fst: sflash_pkg::F_IDLE,
		cst: sflash_pkg::C_IDLE,
		proto: proto_of(VOLATILE_ENHANCED_CONFIG_REG_INIT),
		nonvolatile_config_reg: NONVOLATILE_CONFIG_REG_INIT,
		volatile_enhanced_config_reg: VOLATILE_ENHANCED_CONFIG_REG_INIT,
		bp: sflash_pkg::BP_RST,
		tx: sflash_pkg::TX_RST,
		default: '0
	};

	state_t st_r;
	state_t st_nxt;
	logic [$bits(sflash_pkg::pin_in_t)-1:0] p_raw;
	sflash_pkg::pin_in_t p;
	sflash_pkg::op_info_t oi;
	logic sel;
	logic rise;
	logic fall;
	logic cs_fall;
	logic dq23_data;
	logic hold_en;
	logic rst_act;
	logic pause;
	logic wp_frozen;
	logic busy;
	logic [2:0] cur_w;
	logic go_rise;
	logic go_fall;
	logic sh_clear;
	logic sh_done;
	logic [7:0] sh_rx;
	logic [3:0] sh_dout;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic [31:0] status;

	pin_sync #(
		.W($bits(sflash_pkg::pin_in_t)),
		.RST(7'h40)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.d(pins),
		.q(p_raw)
	);

	lane_shifter u_shift (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.clear(sh_clear),
		.rise(go_rise),
		.fall(go_fall),
		.load(st_r.load),
		.width(cur_w),
		.din(p.dq),
		.tx_byte(st_r.tx),
		.done(sh_done),
		.rx_byte(sh_rx),
		.dout(sh_dout)
	);

	always_comb
	begin
		p = sflash_pkg::pin_in_t'(p_raw);
		sel = !p.cs_n;
		oi = decode(st_r.opcode, st_r.proto);
		busy = st_r.cst != sflash_pkg::C_IDLE;
		// input latched on rising, output moved on falling [R16] [R25]
		rise = p.sclk && !st_r.sclk_prev;
		fall = !p.sclk && st_r.sclk_prev;
		cs_fall = st_r.cs_prev && !p.cs_n;
		// pins 2 and 3 act as data lines [R09] [R10] [R13]
		dq23_data = sel && (st_r.proto == sflash_pkg::P_QUAD
			|| (st_r.fst inside {sflash_pkg::F_ADDR, sflash_pkg::F_DATA} && oi.quad));
		hold_en = st_r.nonvolatile_config_reg[sflash_pkg::NV_HOLD_EN] && st_r.volatile_enhanced_config_reg[sflash_pkg::VE_HOLD_EN]; // [R11]
		rst_act = RESET_VARIANT && hold_en && !dq23_data && !p.dq[3]; // [R07] [R10]
		// pause only counts once selected in a frame [R05] [R06]
		pause = !RESET_VARIANT && hold_en && sel && st_r.fst != sflash_pkg::F_IDLE
			&& !dq23_data && !p.dq[3];
		wp_frozen = st_r.proto == sflash_pkg::P_SINGLE && !dq23_data && !p.dq[2]; // [R12]
		case (st_r.fst)
			sflash_pkg::F_OPC: cur_w = st_r.proto == sflash_pkg::P_QUAD ? 3'd4
				: st_r.proto == sflash_pkg::P_DUAL ? 3'd2 : 3'd1; // [R19]
			sflash_pkg::F_ADDR: cur_w = oi.addr_w;
			sflash_pkg::F_DATA: cur_w = oi.data_w;
			default: cur_w = 3'd1;
		endcase
		go_rise = rise && sel && !pause && !rst_act && (st_r.fst == sflash_pkg::F_OPC
			|| st_r.fst == sflash_pkg::F_ADDR
			|| (st_r.fst == sflash_pkg::F_DATA && !oi.is_read));
		go_fall = fall && sel && !pause && !rst_act && st_r.fst == sflash_pkg::F_DATA
			&& oi.is_read;
		sh_clear = !sel || rst_act || cs_fall;
		wmask = {{8{st_r.wstrb[3]}}, {8{st_r.wstrb[2]}}, {8{st_r.wstrb[1]}},
			{8{st_r.wstrb[0]}}};
		status = 32'h0000_0000;
		status[sflash_pkg::ST_PROTO +: 2] = st_r.proto;
		status[sflash_pkg::ST_SEL] = sel;
		status[sflash_pkg::ST_ACT] = st_r.active;
		status[sflash_pkg::ST_BUSY] = busy;
		status[sflash_pkg::ST_PAUSE] = pause;
		status[sflash_pkg::ST_INRST] = rst_act;
		status[sflash_pkg::ST_LOST] = st_r.lost;
		status[sflash_pkg::ST_BOOST] = st_r.boosted;
		status[sflash_pkg::ST_WPFRZ] = wp_frozen;
	end

	always_comb
	begin
		st_nxt = st_r;
		wval = 32'h0000_0000;
		st_nxt.cs_prev = p.cs_n;
		st_nxt.sclk_prev = p.sclk;
		st_nxt.load = 1'b0;
		// register writes, address and data in either order
		if (axi_req.awvalid && axi_rsp.awready)
		begin
			st_nxt.aw_ok = 1'b1;
			st_nxt.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && axi_rsp.wready)
		begin
			st_nxt.w_ok = 1'b1;
			st_nxt.wdata = axi_req.wdata;
			st_nxt.wstrb = axi_req.wstrb;
		end
		if (st_r.bvalid && axi_req.bready)
			st_nxt.bvalid = 1'b0;
		if (st_r.aw_ok && st_r.w_ok)
		begin
			st_nxt.aw_ok = 1'b0;
			st_nxt.w_ok = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = sflash_pkg::RESP_OKAY;
			case (st_r.aw_addr & 8'hfc)
				sflash_pkg::REG_NONVOLATILE_CONFIG_REG:
				begin
					wval = ({16'h0000, st_r.nonvolatile_config_reg} & ~wmask) | (st_r.wdata & wmask);
					st_nxt.nonvolatile_config_reg = wval[15:0];
				end
				sflash_pkg::REG_VOLATILE_ENHANCED_CONFIG_REG:
				begin
					wval = ({24'h000000, st_r.volatile_enhanced_config_reg} & ~wmask) | (st_r.wdata & wmask);
					st_nxt.volatile_enhanced_config_reg = wval[7:0];
				end
				sflash_pkg::REG_STAT:
					if (st_r.wstrb[0] && st_r.wdata[sflash_pkg::ST_LOST])
						st_nxt.lost = 1'b0;
				sflash_pkg::REG_BP:
					if (st_r.wstrb[0] && !wp_frozen) // [R12]
						st_nxt.bp = st_r.wdata[3:0];
				sflash_pkg::REG_TX:
					if (st_r.wstrb[0])
						st_nxt.tx = st_r.wdata[7:0];
				sflash_pkg::REG_RX: st_nxt.bresp = sflash_pkg::RESP_OKAY;
				default: st_nxt.bresp = sflash_pkg::RESP_SLVERR;
			endcase
		end
		// register reads
		if (st_r.rvalid && axi_req.rready)
			st_nxt.rvalid = 1'b0;
		if (axi_req.arvalid && axi_rsp.arready)
		begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = sflash_pkg::RESP_OKAY;
			case (axi_req.araddr & 8'hfc)
				sflash_pkg::REG_NONVOLATILE_CONFIG_REG: st_nxt.rdata = {16'h0000, st_r.nonvolatile_config_reg};
				sflash_pkg::REG_VOLATILE_ENHANCED_CONFIG_REG: st_nxt.rdata = {24'h000000, st_r.volatile_enhanced_config_reg};
				sflash_pkg::REG_STAT: st_nxt.rdata = status;
				sflash_pkg::REG_BP: st_nxt.rdata = {28'h0000000, st_r.bp};
				sflash_pkg::REG_TX: st_nxt.rdata = {24'h000000, st_r.tx};
				sflash_pkg::REG_RX:
					st_nxt.rdata = {8'h00, st_r.byte_cnt, st_r.data_byte, st_r.opcode};
				default:
				begin
					st_nxt.rdata = 32'h0000_0000;
					st_nxt.rresp = sflash_pkg::RESP_SLVERR;
				end
			endcase
		end
		// protocol switches only between frames [R18] [R21] [R24]
		if (st_r.fst == sflash_pkg::F_IDLE)
			st_nxt.proto = proto_of(st_r.volatile_enhanced_config_reg);
		// internal program cycle
		case (st_r.cst)
			sflash_pkg::C_WAIT:
			begin
				st_nxt.cnt = st_r.cnt + 1'b1;
				if (p.vpp_sense)
				begin
					st_nxt.cst = sflash_pkg::C_RUN;
					st_nxt.boosted = 1'b1;
					st_nxt.cnt = '0;
				end
				else if (st_r.cnt == sflash_pkg::CNT_W'(BOOST_WAIT - 1)) // [R15]
				begin
					st_nxt.cst = sflash_pkg::C_RUN;
					st_nxt.cnt = '0;
				end
			end
			sflash_pkg::C_RUN:
			begin
				st_nxt.cnt = st_r.cnt + 1'b1;
				if (st_r.cnt == (st_r.boosted ? sflash_pkg::CNT_W'(FAST - 1)
					: sflash_pkg::CNT_W'(PROG - 1)))
					st_nxt.cst = sflash_pkg::C_IDLE;
			end
			default: st_nxt.cnt = '0;
		endcase
		// frame handling
		if (rst_act || !sel)
		begin
			// partial instructions are dropped, program starts only when complete [R26]
			if (!rst_act && st_r.fst == sflash_pkg::F_DATA && oi.is_prog
				&& st_r.byte_cnt != 8'h00 && !busy)
			begin
				st_nxt.cnt = '0;
				st_nxt.boosted = 1'b0;
				// boost wait only when enabled [R14] [R15]
				if (oi.quad && !st_r.volatile_enhanced_config_reg[sflash_pkg::VE_VPP_DIS])
					st_nxt.cst = sflash_pkg::C_WAIT;
				else
					st_nxt.cst = sflash_pkg::C_RUN;
			end
			st_nxt.fst = sflash_pkg::F_IDLE;
			st_nxt.drv = 1'b0;
		end
		else if (cs_fall) // [R04] [R26]
		begin
			st_nxt.fst = sflash_pkg::F_OPC;
			st_nxt.byte_cnt = 8'h00;
			st_nxt.drv = 1'b0;
		end
		else if (sh_done)
		begin
			case (st_r.fst)
				sflash_pkg::F_OPC:
				begin
					st_nxt.opcode = sh_rx;
					st_nxt.byte_cnt = 8'h00;
					st_nxt.fst = sflash_pkg::F_ADDR;
				end
				sflash_pkg::F_ADDR:
				begin
					st_nxt.byte_cnt = st_r.byte_cnt + 1'b1;
					if (st_r.byte_cnt == 8'(AB - 1))
					begin
						st_nxt.byte_cnt = 8'h00;
						st_nxt.fst = sflash_pkg::F_DATA;
						st_nxt.load = oi.is_read;
					end
				end
				sflash_pkg::F_DATA:
				begin
					st_nxt.data_byte = sh_rx;
					if (st_r.byte_cnt != 8'hff)
						st_nxt.byte_cnt = st_r.byte_cnt + 1'b1;
				end
				default: st_nxt.fst = sflash_pkg::F_IDLE;
			endcase
		end
		if (go_fall)
			st_nxt.drv = 1'b1;
		// a reset during the internal cycle aborts it, set wins over clear [R08]
		if (rst_act && busy)
		begin
			st_nxt.cst = sflash_pkg::C_IDLE;
			st_nxt.cnt = '0;
			st_nxt.lost = 1'b1;
		end
		// deselected, paused or reset: all lines float [R01] [R05] [R07]
		st_nxt.oe = 4'h0;
		if (sel && !rst_act && !pause && st_r.fst == sflash_pkg::F_DATA && oi.is_read
			&& (st_r.drv || go_fall))
			st_nxt.oe = cur_w == 3'd4 ? 4'hf : cur_w == 3'd2 ? 4'h3 : 4'h2;
		st_nxt.active = sel || (st_nxt.cst != sflash_pkg::C_IDLE); // [R02] [R03]
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_r <= ST_RST;
		else if (ce)
			st_r <= st_nxt;
	end

	always_comb
	begin
		axi_rsp.awready = !st_r.aw_ok && !st_r.bvalid;
		axi_rsp.wready = !st_r.w_ok && !st_r.bvalid;
		axi_rsp.bvalid = st_r.bvalid;
		axi_rsp.bresp = st_r.bresp;
		axi_rsp.arready = !st_r.rvalid;
		axi_rsp.rvalid = st_r.rvalid;
		axi_rsp.rdata = st_r.rdata;
		axi_rsp.rresp = st_r.rresp;
		pins_out.dq_out = sh_dout;
		pins_out.dq_oe = st_r.oe;
		active_power = st_r.active;
	end
endmodule

/* File: hw/sflash_pkg.sv */
// constants, enumerations and carriers of the serial flash bus front end
// assumes a 40 MHz aclk and an axi4-lite master with 8-bit byte addresses
package sflash_pkg;
	// clock and timing
	localparam int CLK_HZ = 40000000;
	localparam int BOOST_WAIT_MS = 200;
	localparam int BOOST_WAIT_CYC = (CLK_HZ / 1000) * BOOST_WAIT_MS;
	localparam int PROG_CYC = 64;
	localparam int FAST_CYC = 16;
	localparam int CNT_W = 24;
	localparam int ADDR_BYTES = 3;
	// register offsets
	localparam logic [7:0] REG_NONVOLATILE_CONFIG_REG = 8'h00;
	localparam logic [7:0] REG_VOLATILE_ENHANCED_CONFIG_REG = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_BP = 8'h0c;
	localparam logic [7:0] REG_TX = 8'h10;
	localparam logic [7:0] REG_RX = 8'h14;
	// reset values
	localparam logic [15:0] NONVOLATILE_CONFIG_REG_RST = 16'hffff;
	localparam logic [7:0] VOLATILE_ENHANCED_CONFIG_REG_RST = 8'hff;
	localparam logic [3:0] BP_RST = 4'h0;
	localparam logic [7:0] TX_RST = 8'h00;
	// configuration bit positions
	localparam int NV_DUAL_N = 2;
	localparam int NV_QUAD_N = 3;
	localparam int NV_HOLD_EN = 3;
	localparam int VE_VPP_DIS = 3;
	localparam int VE_HOLD_EN = 4;
	localparam int VE_DUAL_N = 6;
	localparam int VE_QUAD_N = 7;
	// status bit positions
	localparam int ST_PROTO = 0;
	localparam int ST_SEL = 2;
	localparam int ST_ACT = 3;
	localparam int ST_BUSY = 4;
	localparam int ST_PAUSE = 5;
	localparam int ST_INRST = 6;
	localparam int ST_LOST = 7;
	localparam int ST_BOOST = 8;
	localparam int ST_WPFRZ = 9;
	// instruction codes, values arbitrary
	localparam logic [7:0] OP_READ = 8'ha1;
	localparam logic [7:0] OP_QOUT_READ = 8'ha2;
	localparam logic [7:0] OP_QIO_READ = 8'ha3;
	localparam logic [7:0] OP_PROG = 8'ha4;
	localparam logic [7:0] OP_QIN_PROG = 8'ha5;
	localparam logic [7:0] OP_QEXT_PROG = 8'ha6;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {P_SINGLE, P_DUAL, P_QUAD} proto_t;
	typedef enum logic [1:0] {F_IDLE, F_OPC, F_ADDR, F_DATA} frame_t;
	typedef enum logic [1:0] {C_IDLE, C_WAIT, C_RUN} cycle_t;
	typedef struct packed {
		logic is_read;
		logic is_prog;
		logic quad;
		logic [2:0] addr_w;
		logic [2:0] data_w;
	} op_info_t;
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic [3:0] dq;
		logic vpp_sense;
	} pin_in_t;
	typedef struct packed {
		logic [3:0] dq_out;
		logic [3:0] dq_oe;
	} pin_out_t;
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_rsp_t;
endpackage
